// file: signal_limit_supervisor.sv
module signal_limit_supervisor
#(
  parameter int NUM_SOURCES = 8
)
(
  input  wire logic                   clk_in,
  input  wire logic                   arst_n_in,
  input  wire logic                   psel_in,
  input  wire logic                   penable_in,
  input  wire logic                   pwrite_in,
  input  wire logic [7:0]             paddr_in,
  input  wire logic [31:0]            pwdata_in,
  output logic [31:0]                 prdata_out,
  output logic                        pready_out,
  output logic                        pslverr_out,
  input  wire logic [NUM_SOURCES-1:0][31:0] source_vals_in,
  input  wire logic                   sample_tick_in,
  input  wire logic                   motor_running_in,
  output logic                        status_out,
  output logic                        warning_out,
  output logic                        fault_out,
  output logic [15:0]                 event_code_out,
  output logic                        irq_out
);
  import sup_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration check.
  // ----------------------------------------------------------------
  // The source field is three bits wide, so at most eight inputs.
  if (NUM_SOURCES < 1 || NUM_SOURCES > 8)
  begin : g_bad_sources
    $error("NUM_SOURCES must be 1 to 8");
  end

  // ----------------------------------------------------------------
  // Declarations.
  // ----------------------------------------------------------------
  ctrl_t              ctrl;
  limits_t            lim;
  logic [14:0]        filt_tc;
  logic [2:0]         istat;
  logic [2:0]         imask;
  logic [2:0]         events;
  logic               run_s1;
  logic               run_s2;
  logic               run_s3;
  logic               running;
  logic               active;
  logic               active_d;
  logic               warn_d;
  logic               fault_d;
  logic               fault_set;
  logic               fault_rst;
  logic signed [31:0] sel_val;
  logic signed [31:0] filt_val;
  logic               wr_acc;
  logic               setup;
  logic               map_hit;
  logic [31:0]        rd_mux;
  logic [31:0]        state_word;

  // ----------------------------------------------------------------
  // APB decode.
  // ----------------------------------------------------------------
  // Writes take effect only at the completing access edge.
  assign setup  = psel_in && !penable_in;
  assign wr_acc = psel_in && penable_in && pready_out && pwrite_in;

  // Address hit test; anything else answers with an error.
  always_comb
  begin
    case (paddr_in)
      CTRL_OFS, FILT_OFS, LOW_OFS, HIGH_OFS, HYST_OFS,
      STATE_OFS, ISTAT_OFS, IMASK_OFS, CMD_OFS: map_hit = 1'b1;
      default: map_hit = 1'b0;
    endcase
  end

  // State word as seen by software.
  assign state_word = {event_code_out, 12'h0, running, fault_out,
                       warning_out, status_out};

  // Read multiplexer; unmapped and write-only offsets read zero.
  always_comb
  begin
    case (paddr_in)
      CTRL_OFS:  rd_mux = {21'h0, ctrl.source, 2'h0, ctrl.action, 1'b0, ctrl.mode};
      FILT_OFS:  rd_mux = {17'h0, filt_tc};
      LOW_OFS:   rd_mux = lim.low;
      HIGH_OFS:  rd_mux = lim.high;
      HYST_OFS:  rd_mux = lim.hyst;
      STATE_OFS: rd_mux = state_word;
      ISTAT_OFS: rd_mux = {29'h0, istat};
      IMASK_OFS: rd_mux = {29'h0, imask};
      default:   rd_mux = 32'h0;
    endcase
  end

  // Ready rises in the first access cycle, so every transfer is two
  // cycles; read data is captured in setup so it is a flop output.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0;
    end
    else
    begin
      pready_out  <= setup;
      pslverr_out <= setup && !map_hit;
      if (setup)
        prdata_out <= pwrite_in ? 32'h0 : rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers.
  // ----------------------------------------------------------------
  // Mode, action and source; all reset to off, no action, current.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      ctrl <= '0;
    else if (wr_acc && paddr_in == CTRL_OFS)
    begin
      ctrl.mode   <= pwdata_in[2:0];
      ctrl.action <= pwdata_in[5:4];
      ctrl.source <= pwdata_in[10:8];
    end
  end

  // Filter time in milliseconds, clamped to thirty seconds.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      filt_tc <= 15'h0;
    else if (wr_acc && paddr_in == FILT_OFS)
      filt_tc <= (pwdata_in > 32'(FT_MAX)) ? FT_MAX : pwdata_in[14:0];
  end

  // Limits clamp rather than wrap, so an overrange write stays sane.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      lim <= '0;
    else if (wr_acc)
    begin
      if (paddr_in == LOW_OFS)
        lim.low <= ($signed(pwdata_in) > LIM_MAX) ? LIM_MAX :
                   ($signed(pwdata_in) < -LIM_MAX) ? -LIM_MAX : $signed(pwdata_in);
      if (paddr_in == HIGH_OFS)
        lim.high <= ($signed(pwdata_in) > LIM_MAX) ? LIM_MAX :
                    ($signed(pwdata_in) < -LIM_MAX) ? -LIM_MAX : $signed(pwdata_in);
      if (paddr_in == HYST_OFS)
        lim.hyst <= (pwdata_in > HYST_MAX) ? HYST_MAX : pwdata_in;
    end
  end

  // ----------------------------------------------------------------
  // Signal path.
  // ----------------------------------------------------------------
  // Unconnected selections read as zero rather than wrapping.
  always_comb
  begin
    sel_val = 32'sh0;
    for (int i = 0; i < NUM_SOURCES; i++)
    begin
      if (int'(ctrl.source) == i)
        sel_val = $signed(source_vals_in[i]);
    end
  end

  lp_filter u_filter
  (
    .clk_in    (clk_in),
    .arst_n_in (arst_n_in),
    .tick_in   (sample_tick_in),
    .tc_in     (filt_tc),
    .x_in      (sel_val),
    .y_out     (filt_val)
  );

  limit_compare u_cmp
  (
    .clk_in     (clk_in),
    .arst_n_in  (arst_n_in),
    .mode_in    (ctrl.mode),
    .lim_in     (lim),
    .value_in   (filt_val),
    .active_out (active)
  );

  // ----------------------------------------------------------------
  // Motor running pin synchroniser.
  // ----------------------------------------------------------------
  // Three stages; the level is accepted only when stages two and three agree.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      run_s1  <= 1'b0;
      run_s2  <= 1'b0;
      run_s3  <= 1'b0;
      running <= 1'b0;
    end
    else
    begin
      run_s1 <= motor_running_in;
      run_s2 <= run_s1;
      run_s3 <= run_s2;
      if (run_s2 == run_s3)
        running <= run_s3;
    end
  end

  // ----------------------------------------------------------------
  // Actions.
  // ----------------------------------------------------------------
  // Fault trips latch; a motor stop does not clear an earlier trip.
  assign fault_set = active && ((ctrl.action == ACT_FAULT) ||
                     (ctrl.action == ACT_FRUN && running));
  assign fault_rst = wr_acc && paddr_in == CMD_OFS && pwdata_in[0];

  // Status follows the comparison whatever the action is.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      status_out <= 1'b0;
    else
      status_out <= active;
  end

  // Warning is a level that drops with the violation.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      warning_out <= 1'b0;
    else
      warning_out <= active && ctrl.action == ACT_WARN;
  end

  // Trip wins over a same-cycle software reset.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      fault_out <= 1'b0;
    else if (fault_set)
      fault_out <= 1'b1;
    else if (fault_rst)
      fault_out <= 1'b0;
  end

  // Fault code outranks the warning code.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      event_code_out <= 16'h0;
    else if (fault_set || (fault_out && !fault_rst))
      event_code_out <= FAULT_CODE;
    else if (active && ctrl.action == ACT_WARN)
      event_code_out <= WARN_CODE;
    else
      event_code_out <= 16'h0;
  end

  // ----------------------------------------------------------------
  // Interrupts.
  // ----------------------------------------------------------------
  // Rising edges of warning, fault and status are the events.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      warn_d   <= 1'b0;
      fault_d  <= 1'b0;
      active_d <= 1'b0;
    end
    else
    begin
      warn_d   <= warning_out;
      fault_d  <= fault_out;
      active_d <= status_out;
    end
  end
  assign events = {status_out && !active_d, fault_out && !fault_d, warning_out && !warn_d};

  // Write one to clear; a new event in the same cycle stays set.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      istat <= 3'h0;
    else if (wr_acc && paddr_in == ISTAT_OFS)
      istat <= (istat & ~pwdata_in[2:0]) | events;
    else
      istat <= istat | events;
  end

  // Mask enables each status bit onto the line.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      imask <= 3'h0;
    else if (wr_acc && paddr_in == IMASK_OFS)
      imask <= pwdata_in[2:0];
  end

  // Registered line lags the status bits by one cycle.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      irq_out <= 1'b0;
    else
      irq_out <= |(istat & imask);
  end

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  property p_status_free;
    $changed(ctrl.action) && $stable(active) |-> status_out == $past(active);
  endproperty
  a_status_free: assert property (p_status_free) else $error("action moved status");

  property p_no_action;
    (ctrl.action == ACT_NONE && !fault_out && !fault_set) |=> !warning_out && !fault_out;
  endproperty
  a_no_action: assert property (p_no_action) else $error("action 0 raised event");

  property p_warn;
    (active && ctrl.action == ACT_WARN && !fault_out) |=>
      warning_out && !fault_out && event_code_out == WARN_CODE;
  endproperty
  a_warn: assert property (p_warn) else $error("warning not raised");

  property p_fault;
    (active && ctrl.action == ACT_FAULT) |=> fault_out && event_code_out == FAULT_CODE;
  endproperty
  a_fault: assert property (p_fault) else $error("fault not tripped");

  sequence s_run_violation;
    active && ctrl.action == ACT_FRUN && running;
  endsequence
  property p_fault_run;
    s_run_violation |=> fault_out;
  endproperty
  a_fault_run: assert property (p_fault_run) else $error("running trip missed");

  property p_fault_idle;
    (ctrl.action == ACT_FRUN && !running && !fault_out) |=> !fault_out;
  endproperty
  a_fault_idle: assert property (p_fault_idle) else $error("idle trip");

  property p_filter_pass;
    (sample_tick_in && filt_tc == 15'h0) |=> filt_val == $past(sel_val);
  endproperty
  a_filter_pass: assert property (p_filter_pass) else $error("filter not transparent");

  property p_range;
    lim.low <= LIM_MAX && lim.low >= -LIM_MAX && lim.high <= LIM_MAX &&
    lim.high >= -LIM_MAX && filt_tc <= FT_MAX && lim.hyst <= HYST_MAX;
  endproperty
  a_range: assert property (p_range) else $error("setting out of range");

  property p_default_src;
    ctrl.source == 3'h0 |-> sel_val == $signed(source_vals_in[0]);
  endproperty
  a_default_src: assert property (p_default_src) else $error("wrong source");

  property p_irq;
    |(istat & imask) |=> irq_out;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");
endmodule

// file: sup_pkg.sv
// Functional notes
// - Mode 4 acts while the value's magnitude exceeds the upper limit's magnitude.
// - Mode 5 acts while the value is under low or over high.
// - Mode 6 acts while the magnitude is under abs low or over abs high.
// - Mode 7 sets above high plus half hysteresis, clears below low minus half.
// - Action selector picks the consequence and never alters supervision status.
// - Action 0 raises neither warning nor fault.
// - Action 1 raises warning code a8b1 and does not trip.
// - Action 2 trips with fault code 80b1.
// - Action 3 trips only while the motor runs, otherwise does nothing.
// - Source selector picks the monitored signal, motor current by default.
// - Filter time constant spans 0 to 30 s at 1000 counts per second.
// - Lower limit is signed hundredths within plus/minus 21474836.00, default zero.
// - Mode 0 off, 1 under low, 2 over high, 3 magnitude under abs low.
// - Upper limit is signed hundredths with the lower limit's range, default zero.
// - Hysteresis 0 to 100000.00 widens set and clear thresholds in every mode.
package sup_pkg;
  // ----------------------------------------------------------------
  // Register offsets (byte addresses).
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] FILT_OFS   = 8'h04;
  localparam logic [7:0] LOW_OFS    = 8'h08;
  localparam logic [7:0] HIGH_OFS   = 8'h0c;
  localparam logic [7:0] HYST_OFS   = 8'h10;
  localparam logic [7:0] STATE_OFS  = 8'h14;
  localparam logic [7:0] ISTAT_OFS  = 8'h18;
  localparam logic [7:0] IMASK_OFS  = 8'h1c;
  localparam logic [7:0] CMD_OFS    = 8'h20;
  // ----------------------------------------------------------------
  // Ranges, codes and reset values.
  // ----------------------------------------------------------------
  localparam logic signed [31:0] LIM_MAX  = 32'sd2147483600;
  localparam logic [31:0]        HYST_MAX = 32'd10000000;
  localparam logic [14:0]        FT_MAX   = 15'd30000;
  localparam int                 FT_COUNTS_PER_S = 1000;
  localparam logic [15:0] WARN_CODE  = 16'ha8b1;
  localparam logic [15:0] FAULT_CODE = 16'h80b1;
  localparam logic [2:0]  MODE_OFF = 3'h0;
  localparam logic [2:0]  MODE_LOW = 3'h1;
  localparam logic [2:0]  MODE_HIGH = 3'h2;
  localparam logic [2:0]  MODE_ALOW = 3'h3;
  localparam logic [2:0]  MODE_AHIGH = 3'h4;
  localparam logic [2:0]  MODE_BOTH = 3'h5;
  localparam logic [2:0]  MODE_ABOTH = 3'h6;
  localparam logic [2:0]  MODE_HYST = 3'h7;
  localparam logic [1:0]  ACT_NONE = 2'h0;
  localparam logic [1:0]  ACT_WARN = 2'h1;
  localparam logic [1:0]  ACT_FAULT = 2'h2;
  localparam logic [1:0]  ACT_FRUN = 2'h3;
  // ----------------------------------------------------------------
  // Carriers.
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] source;
    logic [1:0] action;
    logic [2:0] mode;
  } ctrl_t;
  typedef struct packed {
    logic signed [31:0] low;
    logic signed [31:0] high;
    logic [31:0]        hyst;
  } limits_t;
  typedef enum logic {SUP_CLEAR, SUP_ACTIVE} sup_state_t;
endpackage

// file: lp_filter.sv
module lp_filter
(
  input  wire logic               clk_in,
  input  wire logic               arst_n_in,
  input  wire logic               tick_in,
  input  wire logic [14:0]        tc_in,
  input  wire logic signed [31:0] x_in,
  output logic signed [31:0]      y_out
);
  import sup_pkg::*;
  logic [3:0]         sh;
  logic signed [32:0] diff;
  logic signed [32:0] step;
  logic signed [32:0] sum;

  // Shift is ceil(log2(tc)); a shift stands in for a divider to save area.
  always_comb
  begin
    sh = 4'h0;
    for (int i = 0; i < 15; i++)
    begin
      if ({17'h0, tc_in} > (32'h1 << i))
        sh = 4'(i + 1);
    end
    diff = {x_in[31], x_in} - {y_out[31], y_out};
    step = diff >>> sh;
    sum  = {y_out[31], y_out} + step;
  end

  // One low-pass step per tick; zero constant copies the input.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      y_out <= 32'h0;
    else if (tick_in)
      y_out <= sum[31:0];
  end
endmodule

// file: limit_compare.sv
module limit_compare
(
  input  wire logic               clk_in,
  input  wire logic               arst_n_in,
  input  wire logic [2:0]         mode_in,
  input  sup_pkg::limits_t        lim_in,
  input  wire logic signed [31:0] value_in,
  output logic                    active_out
);
  import sup_pkg::*;
  logic signed [34:0] v, av, lo, hi, alo, ahi, h;
  logic on, off;
  sup_state_t st;

  // Doubled values keep half the hysteresis exact. Release is inclusive in modes 1 to 6,
  // so there, with zero hysteresis, a value sitting exactly on a limit is not a violation.
  always_comb
  begin
    v   = 35'(value_in) <<< 1;
    lo  = 35'(lim_in.low) <<< 1;
    hi  = 35'(lim_in.high) <<< 1;
    h   = {3'h0, lim_in.hyst};
    av  = v[34] ? -v : v;
    alo = lo[34] ? -lo : lo;
    ahi = hi[34] ? -hi : hi;
    on  = 1'b0;
    off = 1'b1;
    case (mode_in)
      MODE_LOW:   begin on = v < lo - h;   off = v >= lo + h; end
      MODE_HIGH:  begin on = v > hi + h;   off = v <= hi - h; end
      MODE_ALOW:  begin on = av < alo - h; off = av >= alo + h; end
      MODE_AHIGH: begin on = av > ahi + h; off = av <= ahi - h; end
      MODE_BOTH:
      begin
        on  = (v < lo - h) || (v > hi + h);
        off = (v >= lo + h) && (v <= hi - h);
      end
      MODE_ABOTH:
      begin
        on  = (av < alo - h) || (av > ahi + h);
        off = (av >= alo + h) && (av <= ahi - h);
      end
      MODE_HYST:  begin on = v > hi + h;   off = v < lo - h; end
      default:    begin on = 1'b0;         off = 1'b1; end
    endcase
  end

  // Set has priority over release while both hold.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      st <= SUP_CLEAR;
    else
      case (st)
        SUP_CLEAR:  if (on) st <= SUP_ACTIVE;
        SUP_ACTIVE: if (!on && off) st <= SUP_CLEAR;
        default:    st <= SUP_CLEAR;
      endcase
  end
  assign active_out = (st == SUP_ACTIVE);

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  property p_abs_high;
    (mode_in == MODE_AHIGH && av > ahi + h) |=> active_out;
  endproperty
  a_abs_high: assert property (p_abs_high) else $error("abs high missed");
  property p_both;
    (mode_in == MODE_BOTH && (v < lo - h || v > hi + h)) |=> active_out;
  endproperty
  a_both: assert property (p_both) else $error("both missed");
  property p_abs_both;
    (mode_in == MODE_ABOTH && av < alo - h) |=> active_out;
  endproperty
  a_abs_both: assert property (p_abs_both) else $error("abs both missed");
  property p_hyst_hold;
    (mode_in == MODE_HYST && active_out && v >= lo - h && $stable(mode_in)) |=> active_out;
  endproperty
  a_hyst_hold: assert property (p_hyst_hold) else $error("hysteresis released early");
endmodule

// file: test_signal_limit_supervisor.sv
module test_signal_limit_supervisor;
  timeunit 1ns;
  timeprecision 1ps;
  import sup_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and observed signals.
  // ----------------------------------------------------------------
  logic              clk_in = 1'b0;
  logic              arst_n_in = 1'b0;
  logic              psel_in = 1'b0;
  logic              penable_in = 1'b0;
  logic              pwrite_in = 1'b0;
  logic [7:0]        paddr_in = 8'h00;
  logic [31:0]       pwdata_in = 32'h0;
  logic [7:0][31:0]  source_vals_in = '0;
  logic              sample_tick_in = 1'b0;
  logic              motor_running_in = 1'b0;
  logic [31:0]       prdata_out;
  logic              pready_out, pslverr_out, status_out, warning_out, fault_out, irq_out;
  logic [15:0]       event_code_out;
  int                errors = 0;
  int                n_tests = 0;

  signal_limit_supervisor u_signal_limit_supervisor (.*);

  // Free-running 4 ns clock.
  initial
  begin
    forever #2 clk_in = ~clk_in;
  end

  // ----------------------------------------------------------------
  // Shared tasks.
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; the request stands until pready is seen at an edge.
  // The wait has no cap of its own, so only the watchdog ends a hung slave.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int i;
    @(posedge clk_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    i = 0;
    do
    begin
      @(posedge clk_in);
      i++;
    end
    while (pready_out !== 1'b1);
    chk("access cycles", 32'd1, 32'(i));
    r = prdata_out;
    e = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk("read data", exp, r);
    chk("pslverr", 32'(exp_err), 32'(e));
  endtask

  // Present a value, give one filter tick, then let the pipeline settle.
  task automatic step(input int idx, input logic [31:0] v);
    source_vals_in[idx] <= v;
    @(posedge clk_in);
    sample_tick_in <= 1'b1;
    @(posedge clk_in);
    sample_tick_in <= 1'b0;
    repeat (6) @(posedge clk_in);
  endtask

  task automatic look(input logic st, input logic wn, input logic ft, input logic [15:0] code);
    chk("status", 32'(st), 32'(status_out));
    chk("warning", 32'(wn), 32'(warning_out));
    chk("fault", 32'(ft), 32'(fault_out));
    chk("event code", 32'(code), 32'(event_code_out));
  endtask

  task automatic set_lim(input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] hy);
    wr(LOW_OFS, lo);
    wr(HIGH_OFS, hi);
    wr(HYST_OFS, hy);
  endtask

  // ----------------------------------------------------------------
  // Scenarios.
  // ----------------------------------------------------------------
  task automatic test_regs();
    rd(CTRL_OFS, 32'h0, 1'b0);
    rd(FILT_OFS, 32'h0, 1'b0);
    rd(LOW_OFS, 32'h0, 1'b0);
    rd(HIGH_OFS, 32'h0, 1'b0);
    rd(HYST_OFS, 32'h0, 1'b0);
    rd(8'h24, 32'h0, 1'b1);
    wr(FILT_OFS, 32'd40000);
    rd(FILT_OFS, 32'd30000, 1'b0);
    wr(LOW_OFS, 32'h80000000);
    rd(LOW_OFS, 32'h80000030, 1'b0);
    wr(HIGH_OFS, 32'h7fffffff);
    rd(HIGH_OFS, 32'h7fffffd0, 1'b0);
    wr(HYST_OFS, 32'd20000000);
    rd(HYST_OFS, 32'd10000000, 1'b0);
    wr(CTRL_OFS, 32'h00000735);
    rd(CTRL_OFS, 32'h00000735, 1'b0);
    wr(STATE_OFS, 32'hffffffff);
    rd(STATE_OFS, 32'h0, 1'b0);
    wr(CTRL_OFS, 32'h0);
    wr(FILT_OFS, 32'h0);
  endtask

  // Modes 0 to 6 with no action selected; the negative values in modes 3, 4 and 6 hit the magnitude paths.
  task automatic test_modes();
    int md [12] = '{0, 1, 1, 2, 2, 3, 4, 5, 6, 6, 6, 6};
    int vv [12] = '{1000, -150, -50, 250, 200, -50, -250, -150, -250, 150, 50, 150};
    logic ex [12] = '{0, 1, 0, 1, 0, 1, 1, 1, 1, 0, 1, 0};
    set_lim(-32'sd100, 32'd200, 32'd0);
    for (int i = 0; i < 12; i++)
    begin
      wr(CTRL_OFS, 32'(md[i]));
      step(0, 32'(vv[i]));
      look(ex[i], 1'b0, 1'b0, 16'h0);
    end
  endtask

  // Half the hysteresis widens set and release, in mode 7 and in mode 2.
  task automatic test_hyst();
    int md [8] = '{7, 7, 7, 7, 2, 2, 2, 2};
    int vv [8] = '{240, 260, -140, -160, 240, 260, 160, 140};
    logic ex [8] = '{0, 1, 1, 0, 0, 1, 1, 0};
    set_lim(-32'sd100, 32'd200, 32'd100);
    for (int i = 0; i < 8; i++)
    begin
      wr(CTRL_OFS, 32'(md[i]));
      step(0, 32'(vv[i]));
      look(ex[i], 1'b0, 1'b0, 16'h0);
    end
    wr(HYST_OFS, 32'd0);
  endtask

  // A time constant of 4 must lag a step; the constant then goes back to zero.
  task automatic test_filter();
    wr(CTRL_OFS, 32'(MODE_HIGH));
    step(0, 32'd0);
    wr(FILT_OFS, 32'd4);
    step(0, 32'd400);
    look(1'b0, 1'b0, 1'b0, 16'h0);
    repeat (7) step(0, 32'd400);
    look(1'b1, 1'b0, 1'b0, 16'h0);
    wr(FILT_OFS, 32'd0);
    step(0, 32'd0);
  endtask

  // Actions on source 3 while the default source stays quiet.
  task automatic test_actions();
    wr(CTRL_OFS, 32'h0300 | 32'(ACT_WARN) << 4 | 32'(MODE_HIGH));
    step(3, 32'd300);
    look(1'b1, 1'b1, 1'b0, WARN_CODE);
    step(3, 32'd0);
    look(1'b0, 1'b0, 1'b0, 16'h0);
    wr(CTRL_OFS, 32'h0300 | 32'(ACT_FAULT) << 4 | 32'(MODE_HIGH));
    step(3, 32'd300);
    look(1'b1, 1'b0, 1'b1, FAULT_CODE);
    step(3, 32'd0);
    look(1'b0, 1'b0, 1'b1, FAULT_CODE);
    wr(CMD_OFS, 32'h1);
    repeat (3) @(posedge clk_in);
    look(1'b0, 1'b0, 1'b0, 16'h0);
    wr(CTRL_OFS, 32'h0300 | 32'(ACT_FRUN) << 4 | 32'(MODE_HIGH));
    step(3, 32'd300);
    look(1'b1, 1'b0, 1'b0, 16'h0);
    step(3, 32'd0);
    motor_running_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    step(3, 32'd300);
    look(1'b1, 1'b0, 1'b1, FAULT_CODE);
    step(3, 32'd0);
    motor_running_in <= 1'b0;
    wr(CMD_OFS, 32'h1);
    wr(CTRL_OFS, 32'(MODE_HIGH));
  endtask

  // A status rise latches in the sticky register; the mask gates the line.
  task automatic test_irq();
    wr(IMASK_OFS, 32'h0);
    wr(ISTAT_OFS, 32'h7);
    step(0, 32'd300);
    chk("irq", 32'h0, 32'(irq_out));
    rd(ISTAT_OFS, 32'h4, 1'b0);
    wr(IMASK_OFS, 32'h4);
    repeat (2) @(posedge clk_in);
    chk("irq", 32'h1, 32'(irq_out));
    wr(ISTAT_OFS, 32'h4);
    repeat (2) @(posedge clk_in);
    chk("irq", 32'h0, 32'(irq_out));
    rd(ISTAT_OFS, 32'h0, 1'b0);
  endtask

  // ----------------------------------------------------------------
  // Run control.
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Main sequence after a reset of ten cycles.
  initial
  begin
    repeat (10) @(posedge clk_in);
    arst_n_in <= 1'b1;
    test_regs();
    test_modes();
    test_hyst();
    test_filter();
    test_actions();
    test_irq();
    complete_run();
  end

  // The run needs well under a thousand cycles; this bound is generous.
  initial
  begin
    repeat (20000) @(posedge clk_in);
    errors++;
    complete_run();
  end
endmodule
